// [src/power_rail_supervisor.sv]
// Rail control, protection, path selection, remote sense and pin control for a two-rail power module.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module power_rail_supervisor #(
  parameter int START_CYCLES = power_rail_supervisor_pkg::START_CYCLES
) (
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Analog monitor flags from comparators.
  input wire logic passOverCurrent,
  input wire logic adjOverCurrent,
  input wire logic boardOverTemp,
  input wire logic stageOverTemp,
  input wire logic adjOverVoltage,
  input wire logic adjPowerGood,
  input wire logic [15:0] inputMillivolts,
  // Power stage controls.
  output logic adjRailEnable,
  output logic passRailEnable,
  output logic [15:0] adjCurrentLimit,
  output logic [15:0] passCurrentLimit,
  output logic [31:0] adjVoltageSet,
  output logic adjCurrentFoldback,
  output logic switcherEnable,
  output logic linearEnable,
  output logic remoteSenseEnable,
  output logic voltageReject,
  // General-purpose pins.
  input wire logic [1:0] gpPinIn,
  output logic [1:0] gpPinOut,
  output logic [1:0] gpPinOe
);

  // Synchronised monitor inputs.
  logic [5:0] monA_q;
  logic [5:0] monB_q;
  logic [15:0] vinA_q;
  logic [15:0] vinB_q;
  logic passOc;
  logic adjOc;
  logic boardOt;
  logic stageOt;
  logic adjOv;
  logic adjPg;


  // Control registers.
  logic adjOnCmd_q;
  logic passOnCmd_q;
  logic [15:0] ilimAdj_q;
  logic [15:0] ilimPass_q;
  logic [31:0] vset_q;
  power_rail_supervisor_pkg::path_mode_type pathMode_q;
  logic senseMode_q;
  logic [3:0] err_q;
  logic adjOtLock_q;
  logic switchSel_q;
  logic [23:0] saved_q;
  logic [23:0] active_q;
  logic rebootPending_q;
  logic [31:0] startCnt_q;
  logic [31:0] rdata_q;
  logic vreject_q;

  // Decoded strobes.
  logic wrCtrl;
  logic wrErr;
  logic wrVset;
  logic vsetOk;

  logic [1:0] pinCfgWe;
  logic [1:0] pinStateWe;
  logic [2:0] pinCfg [2];
  logic [1:0] pinLevel;
  power_rail_supervisor_pkg::rail_state_type railState;
  logic adjFault;

  assign wrCtrl = clkEn && regWr && regAddr == power_rail_supervisor_pkg::REG_RAIL_CTRL;
  assign wrErr = clkEn && regWr && regAddr == power_rail_supervisor_pkg::REG_ERRORS;
  assign wrVset = clkEn && regWr && regAddr == power_rail_supervisor_pkg::REG_VSET;
  assign vsetOk = regWdata >= power_rail_supervisor_pkg::VSET_MIN_UV &&
                  regWdata <= power_rail_supervisor_pkg::VSET_MAX_UV;

  // Two flip-flops on every analog monitor input.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      monA_q <= 6'h00;
      monB_q <= 6'h00;
      vinA_q <= 16'h0000;
      vinB_q <= 16'h0000;
    end else if (clkEn) begin
      monA_q <= {adjPowerGood, adjOverVoltage, stageOverTemp, boardOverTemp, adjOverCurrent, passOverCurrent};
      monB_q <= monA_q;
      vinA_q <= inputMillivolts;
      vinB_q <= vinA_q;
    end
  end
  assign {adjPg, adjOv, stageOt, boardOt, adjOc, passOc} = monB_q;

  // Rail on/off commands; pass-through enable refused while its error stands.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      adjOnCmd_q <= 1'b0;
      passOnCmd_q <= 1'b0;
    end else if (clkEn) begin
      if (wrCtrl) begin
        adjOnCmd_q <= regWdata[0];
      end
      if (passOnCmd_q && passOc) begin
        passOnCmd_q <= 1'b0;
      end else if (wrCtrl) begin
        passOnCmd_q <= regWdata[1] && !err_q[power_rail_supervisor_pkg::ERR_PASS_OC_BIT];
      end
    end
  end

  // Overheat lock: set on trip, released only by an off command.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      adjOtLock_q <= 1'b0;
    end else if (clkEn) begin
      if (boardOt) begin
        adjOtLock_q <= 1'b1;
      end else if (wrCtrl && !regWdata[0]) begin
        adjOtLock_q <= 1'b0;
      end
    end
  end

  // Current limits, clamped to the three-ampere ceiling.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ilimAdj_q <= power_rail_supervisor_pkg::ILIM_RESET_MA;
      ilimPass_q <= power_rail_supervisor_pkg::ILIM_RESET_MA;
    end else if (clkEn && regWr) begin
      if (regAddr == power_rail_supervisor_pkg::REG_ILIM_ADJ) begin
        ilimAdj_q <= (regWdata[15:0] > power_rail_supervisor_pkg::ILIM_MAX_MA) ?
                     power_rail_supervisor_pkg::ILIM_MAX_MA : regWdata[15:0];
      end
      if (regAddr == power_rail_supervisor_pkg::REG_ILIM_PASS) begin
        ilimPass_q <= (regWdata[15:0] > power_rail_supervisor_pkg::ILIM_MAX_MA) ?
                      power_rail_supervisor_pkg::ILIM_MAX_MA : regWdata[15:0];
      end
    end
  end

  // Voltage set point in microvolts; out-of-range writes keep the old value.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vset_q <= power_rail_supervisor_pkg::VSET_RESET_UV;
      vreject_q <= 1'b0;
    end else if (clkEn) begin
      vreject_q <= wrVset && !vsetOk;
      if (wrVset && vsetOk) begin
        vset_q <= regWdata;
      end
    end
  end

  // Path mode and remote-sense request; illegal mode codes are ignored.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pathMode_q <= power_rail_supervisor_pkg::PATH_SELECT_LINEAR_ONLY;
      senseMode_q <= power_rail_supervisor_pkg::REMOTE_SENSE_OFF;
    end else if (clkEn && regWr) begin
      if (regAddr == power_rail_supervisor_pkg::REG_PATH_MODE && regWdata[1:0] != 2'h2) begin
        pathMode_q <= power_rail_supervisor_pkg::path_mode_type'(regWdata[1:0]);
      end
      if (regAddr == power_rail_supervisor_pkg::REG_SENSE) begin
        senseMode_q <= regWdata[0];
      end
    end
  end

  // Automatic switcher selection with hysteresis below the threshold.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      switchSel_q <= 1'b0;
    end else if (clkEn) begin
      if (vinB_q > power_rail_supervisor_pkg::SWITCH_UP_MV) begin
        switchSel_q <= 1'b1;
      end else if (vinB_q < power_rail_supervisor_pkg::SWITCH_UP_MV - power_rail_supervisor_pkg::HYSTERESIS_MV) begin
        switchSel_q <= 1'b0;
      end
    end
  end

  // Sticky trip flags; a new trip wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_q <= 4'h0;
    end else if (clkEn) begin
      err_q[power_rail_supervisor_pkg::ERR_PASS_OC_BIT] <= (passOnCmd_q && passOc) ||
        (err_q[power_rail_supervisor_pkg::ERR_PASS_OC_BIT] &&
         !(wrErr && regWdata[power_rail_supervisor_pkg::ERR_PASS_OC_BIT]));
      err_q[power_rail_supervisor_pkg::ERR_ADJ_OT_BIT] <= (boardOt && !adjOtLock_q) ||
        (err_q[power_rail_supervisor_pkg::ERR_ADJ_OT_BIT] &&
         !(wrErr && regWdata[power_rail_supervisor_pkg::ERR_ADJ_OT_BIT]));
      err_q[power_rail_supervisor_pkg::ERR_ADJ_OV_BIT] <= (adjOv && adjOnCmd_q) ||
        (err_q[power_rail_supervisor_pkg::ERR_ADJ_OV_BIT] &&
         !(wrErr && regWdata[power_rail_supervisor_pkg::ERR_ADJ_OV_BIT]));
      err_q[power_rail_supervisor_pkg::ERR_VSET_BIT] <= (wrVset && !vsetOk) ||
        (err_q[power_rail_supervisor_pkg::ERR_VSET_BIT] &&
         !(wrErr && regWdata[power_rail_supervisor_pkg::ERR_VSET_BIT]));
    end
  end

  // Saved settings become active only on a reboot after a save.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      saved_q <= power_rail_supervisor_pkg::SAVED_RESET;
      active_q <= power_rail_supervisor_pkg::SAVED_RESET;
      rebootPending_q <= 1'b0;
    end else if (clkEn) begin
      if (regWr && regAddr == power_rail_supervisor_pkg::REG_SAVED) begin
        saved_q <= regWdata[23:0];
      end
      if (regWr && regAddr == power_rail_supervisor_pkg::REG_SAVE_CMD) begin
        if (regWdata[power_rail_supervisor_pkg::SAVE_BIT]) begin
          rebootPending_q <= 1'b1;
        end else if (regWdata[power_rail_supervisor_pkg::REBOOT_BIT] && rebootPending_q) begin
          active_q <= saved_q;
          rebootPending_q <= 1'b0;
        end
      end
    end
  end

  // Startup counter, restarted whenever the adjustable rail is off.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      startCnt_q <= 32'h00000000;
    end else if (clkEn) begin
      if (!adjRailEnable) begin
        startCnt_q <= 32'h00000000;
      end else if (startCnt_q < START_CYCLES[31:0]) begin
        startCnt_q <= startCnt_q + 32'h00000001;
      end
    end
  end

  // Operational state of the adjustable rail.
  assign adjFault = adjOv || adjOtLock_q;
  always_comb begin
    if (stageOt) begin
      railState = power_rail_supervisor_pkg::RAIL_STATE_LINEAR_OVERHEAT;
    end else if (adjFault || (adjRailEnable && startCnt_q >= START_CYCLES[31:0] && !adjPg)) begin
      railState = power_rail_supervisor_pkg::RAIL_STATE_FAULT;
    end else if (adjRailEnable && startCnt_q >= START_CYCLES[31:0]) begin
      railState = power_rail_supervisor_pkg::RAIL_STATE_GOOD;
    end else begin
      railState = power_rail_supervisor_pkg::RAIL_STATE_STARTING;
    end
  end

  // Power stage drive.
  assign adjRailEnable = adjOnCmd_q && !adjOtLock_q && !boardOt && !adjOv;
  assign passRailEnable = passOnCmd_q && !passOc;
  assign adjCurrentLimit = ilimAdj_q;
  assign passCurrentLimit = ilimPass_q;
  assign adjVoltageSet = vset_q;
  assign adjCurrentFoldback = adjRailEnable && adjOc;
  assign linearEnable = adjRailEnable && !stageOt;
  assign switcherEnable = linearEnable && (pathMode_q == power_rail_supervisor_pkg::PATH_SELECT_SWITCH_THEN_LINEAR ||
                          (pathMode_q == power_rail_supervisor_pkg::PATH_SELECT_AUTOMATIC && switchSel_q));
  assign remoteSenseEnable = senseMode_q && !(adjFault || stageOt);
  assign voltageReject = vreject_q;

  // Pin strobes.
  assign pinCfgWe[0] = regWr && regAddr == power_rail_supervisor_pkg::REG_PIN_CFG;
  assign pinCfgWe[1] = pinCfgWe[0];
  assign pinStateWe[0] = regWr && regAddr == power_rail_supervisor_pkg::REG_PIN_STATE;
  assign pinStateWe[1] = pinStateWe[0];

  // One cell per general-purpose pin.
  for (genvar i = 0; i < 2; i++) begin : gPin
    gp_pin_cell uCell (
      .clk(clk),
      .rst_b(rst_b),
      .clkEn(clkEn),
      .cfgWe(pinCfgWe[i]),
      .cfgWdata(regWdata[4*i+2:4*i]),
      .stateWe(pinStateWe[i]),
      .stateWdata(regWdata[i]),
      .cfgQ(pinCfg[i]),
      .levelQ(pinLevel[i]),
      .pinIn(gpPinIn[i]),
      .pinOut(gpPinOut[i]),
      .pinOe(gpPinOe[i])
    );
  end

  // Read data, registered one cycle after the read strobe; unmapped reads zero.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h00000000;
    end else if (clkEn) begin
      rdata_q <= 32'h00000000;
      if (regRd) begin
        unique case (regAddr)
          power_rail_supervisor_pkg::REG_RAIL_CTRL: rdata_q <= {28'h0000000, adjRailEnable, passRailEnable,
                                                                passOnCmd_q, adjOnCmd_q};
          power_rail_supervisor_pkg::REG_ILIM_ADJ:
            rdata_q <= {16'h0000, ilimAdj_q};
          power_rail_supervisor_pkg::REG_ILIM_PASS:
            rdata_q <= {16'h0000, ilimPass_q};
          power_rail_supervisor_pkg::REG_VSET:
            rdata_q <= vset_q;
          power_rail_supervisor_pkg::REG_PATH_MODE:
            rdata_q <= {29'h00000000, switcherEnable, pathMode_q};
          power_rail_supervisor_pkg::REG_RAIL_STATE:
            rdata_q <= {30'h00000000, railState};
          power_rail_supervisor_pkg::REG_SENSE:
            rdata_q <= {30'h00000000, remoteSenseEnable, senseMode_q};
          power_rail_supervisor_pkg::REG_ERRORS:
            rdata_q <= {28'h0000000, err_q};
          power_rail_supervisor_pkg::REG_PIN_CFG:
            rdata_q <= {25'h0000000, pinCfg[1], 1'b0, pinCfg[0]};
          power_rail_supervisor_pkg::REG_PIN_STATE:
            rdata_q <= {30'h00000000, pinLevel};
          power_rail_supervisor_pkg::REG_SAVED:
            rdata_q <= {8'h00, saved_q};
          power_rail_supervisor_pkg::REG_SAVE_CMD:
            rdata_q <= {31'h00000000, rebootPending_q};
          power_rail_supervisor_pkg::REG_ACTIVE:
            rdata_q <= {8'h00, active_q};
          default: rdata_q <= 32'h00000000;
        endcase
      end
    end
  end
  assign regRdata = rdata_q;

endmodule
`default_nettype wire

// [src/power_rail_supervisor_pkg.sv]
// Package with register map, encodings and timing constants for the power rail supervisor.
// Contract
// - Software turns each rail on or off.
// - Per-rail current limit zero to three amperes.
// - Adjustable rail over-current lowers voltage, stays on.
// - Pass-through rail over-current switches rail off.
// - Pass-through stays off until error cleared.
// - Voltage in microvolts; out-of-range rejected.
// - Path mode 0 auto, 1 linear, 3 switcher.
// - Reset path mode is linear-only.
// - Auto: switcher above 7.25 V, 100 mV hysteresis.
// - Over-temperature disables the adjustable rail.
// - After overheat, need off then on.
// - Over-voltage disables adjustable rail at once.
// - Over-voltage gone: rail resumes by itself.
// - State 0 starting, 1 good, 2 fault, 3 overheat.
// - Linear stage off while stage overheated.
// - Remote-sense mode setting; forced off on fault (code: not forced off when the fault is only a missing power-good).
// - Actual remote-sense state reported separately.
// - Pin config 0 input, 1 output, 4 floating.
// - Output pin drives written level; readable.
// - Floating pin undriven; state writes ignored.
// - Saved settings take effect after save, reboot.
package power_rail_supervisor_pkg;

  // Register byte addresses.
  localparam logic [7:0] REG_RAIL_CTRL = 8'h00;
  localparam logic [7:0] REG_ILIM_ADJ = 8'h04;
  localparam logic [7:0] REG_ILIM_PASS = 8'h08;
  localparam logic [7:0] REG_VSET = 8'h0C;
  localparam logic [7:0] REG_PATH_MODE = 8'h10;
  localparam logic [7:0] REG_RAIL_STATE = 8'h14;
  localparam logic [7:0] REG_SENSE = 8'h18;
  localparam logic [7:0] REG_ERRORS = 8'h1C;
  localparam logic [7:0] REG_PIN_CFG = 8'h20;
  localparam logic [7:0] REG_PIN_STATE = 8'h24;
  localparam logic [7:0] REG_SAVED = 8'h28;
  localparam logic [7:0] REG_SAVE_CMD = 8'h2C;
  localparam logic [7:0] REG_ACTIVE = 8'h30;

  // Field positions.
  localparam int ERR_PASS_OC_BIT = 0;
  localparam int ERR_ADJ_OT_BIT = 1;
  localparam int ERR_ADJ_OV_BIT = 2;
  localparam int ERR_VSET_BIT = 3;
  localparam int SAVE_BIT = 0;
  localparam int REBOOT_BIT = 1;

  // Limits: current in milliamperes, voltage in microvolts, input in millivolts.
  localparam logic [15:0] ILIM_MAX_MA = 16'h0BB8;
  localparam logic [31:0] VSET_MIN_UV = 32'h00000000;
  localparam logic [31:0] VSET_MAX_UV = 32'h004C4B40;
  localparam logic [15:0] SWITCH_UP_MV = 16'h1C52;
  localparam logic [15:0] HYSTERESIS_MV = 16'h0064;

  // Reset values.
  localparam logic [15:0] ILIM_RESET_MA = 16'h0BB8;
  localparam logic [31:0] VSET_RESET_UV = 32'h004C4B40;
  localparam logic [23:0] SAVED_RESET = 24'h000000;

  // Startup settle time and its cycle count at 125 MHz.
  localparam int START_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int START_CYCLES = (START_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Encodings.
  typedef enum logic [1:0] {
    PATH_SELECT_AUTOMATIC = 2'h0,
    PATH_SELECT_LINEAR_ONLY = 2'h1,
    PATH_SELECT_SWITCH_THEN_LINEAR = 2'h3
  } path_mode_type;

  typedef enum logic [1:0] {
    RAIL_STATE_STARTING = 2'h0,
    RAIL_STATE_GOOD = 2'h1,
    RAIL_STATE_FAULT = 2'h2,
    RAIL_STATE_LINEAR_OVERHEAT = 2'h3
  } rail_state_type;

  typedef enum logic [2:0] {
    PIN_CFG_INPUT = 3'h0,
    PIN_CFG_OUTPUT = 3'h1,
    PIN_CFG_FLOATING = 3'h4
  } pin_cfg_type;

  localparam logic REMOTE_SENSE_OFF = 1'b0;
  localparam logic REMOTE_SENSE_ON = 1'b1;

endpackage

// [src/gp_pin_cell.sv]
// One general-purpose pin cell with configuration, drive and synchronised read-back.
`timescale 1ns/10ps
`default_nettype none
module gp_pin_cell (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // Software side.
  input wire logic cfgWe,
  input wire logic [2:0] cfgWdata,
  input wire logic stateWe,
  input wire logic stateWdata,
  output logic [2:0] cfgQ,
  output logic levelQ,
  // Pin side.
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe
);

  logic [2:0] cfg_q;
  logic drive_q;
  logic syncA_q;
  logic syncB_q;

  // Configuration accepts only the three legal codes.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= power_rail_supervisor_pkg::PIN_CFG_INPUT;
    end else if (clkEn && cfgWe) begin
      if (cfgWdata == power_rail_supervisor_pkg::PIN_CFG_INPUT ||
          cfgWdata == power_rail_supervisor_pkg::PIN_CFG_OUTPUT ||
          cfgWdata == power_rail_supervisor_pkg::PIN_CFG_FLOATING) begin
        cfg_q <= cfgWdata;
      end
    end
  end

  // Drive level is stored unless the pin floats.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_q <= 1'b0;
    end else if (clkEn && stateWe && cfg_q != power_rail_supervisor_pkg::PIN_CFG_FLOATING) begin
      drive_q <= stateWdata;
    end
  end

  // Two-stage synchroniser for the pin level.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
    end else if (clkEn) begin
      syncA_q <= pinIn;
      syncB_q <= syncA_q;
    end
  end

  assign pinOut = drive_q;
  assign pinOe = (cfg_q == power_rail_supervisor_pkg::PIN_CFG_OUTPUT);
  assign cfgQ = cfg_q;
  assign levelQ = (cfg_q == power_rail_supervisor_pkg::PIN_CFG_FLOATING) ? 1'b0 : syncB_q;

endmodule
`default_nettype wire

// [test/power_rail_supervisor_chk.sv]
// Concurrent checks on the ports of the power rail supervisor.
`timescale 1ns/10ps
`default_nettype none
module power_rail_supervisor_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  // Monitor flags.
  input wire logic passOverCurrent,
  input wire logic boardOverTemp,
  input wire logic stageOverTemp,
  input wire logic adjOverVoltage,
  // Stage controls and pins.
  input wire logic adjRailEnable,
  input wire logic passRailEnable,
  input wire logic [15:0] adjCurrentLimit,
  input wire logic [15:0] passCurrentLimit,
  input wire logic adjCurrentFoldback,
  input wire logic linearEnable,
  input wire logic remoteSenseEnable,
  input wire logic voltageReject,
  input wire logic [1:0] gpPinOe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Each property watches design outputs; monitor flags pass a two-stage synchroniser.
  property p_rdIdle;
    !$past(regRd) |-> regRdata == 32'h0;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside slot");
  property p_passTrip;
    passRailEnable && passOverCurrent |-> ##[1:4] !passRailEnable;
  endproperty
  a_passTrip: assert property (p_passTrip) else $error("pass rail not tripped");
  property p_passRise;
    $rose(passRailEnable) |-> $past(regWr && regAddr == power_rail_supervisor_pkg::REG_RAIL_CTRL && regWdata[1]);
  endproperty
  a_passRise: assert property (p_passRise) else $error("pass rail on without command");
  property p_ovOff;
    adjOverVoltage [*3] |-> !adjRailEnable && !remoteSenseEnable;
  endproperty
  a_ovOff: assert property (p_ovOff) else $error("rail on under over-voltage");
  property p_otOff;
    boardOverTemp [*3] |-> !adjRailEnable;
  endproperty
  a_otOff: assert property (p_otOff) else $error("rail on under over-temperature");
  property p_linOff;
    stageOverTemp [*3] |-> !linearEnable;
  endproperty
  a_linOff: assert property (p_linOff) else $error("linear stage on while hot");
  property p_fold;
    adjCurrentFoldback |-> adjRailEnable;
  endproperty
  a_fold: assert property (p_fold) else $error("foldback with rail off");
  property p_limit;
    adjCurrentLimit <= power_rail_supervisor_pkg::ILIM_MAX_MA &&
      passCurrentLimit <= power_rail_supervisor_pkg::ILIM_MAX_MA;
  endproperty
  a_limit: assert property (p_limit) else $error("current limit above range");
  property p_reject;
    voltageReject |-> $past(regWr && regAddr == power_rail_supervisor_pkg::REG_VSET &&
      regWdata > power_rail_supervisor_pkg::VSET_MAX_UV);
  endproperty
  a_reject: assert property (p_reject) else $error("reject without bad write");
  property p_pinOe;
    $rose(gpPinOe[0]) |-> $past(regWr && regAddr == power_rail_supervisor_pkg::REG_PIN_CFG && regWdata[2:0] == 3'h1);
  endproperty
  a_pinOe: assert property (p_pinOe) else $error("pin drives without config");
  // Main scenarios reached.
  c_trip: cover property (passRailEnable ##1 !passRailEnable);
  c_reject: cover property (voltageReject);
  c_ov: cover property (adjRailEnable ##1 !adjRailEnable && adjOverVoltage);
endmodule

bind power_rail_supervisor power_rail_supervisor_chk i_power_rail_supervisor_chk (
  .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .passOverCurrent(passOverCurrent), .boardOverTemp(boardOverTemp),
  .stageOverTemp(stageOverTemp), .adjOverVoltage(adjOverVoltage), .adjRailEnable(adjRailEnable),
  .passRailEnable(passRailEnable), .adjCurrentLimit(adjCurrentLimit), .passCurrentLimit(passCurrentLimit),
  .adjCurrentFoldback(adjCurrentFoldback), .linearEnable(linearEnable), .remoteSenseEnable(remoteSenseEnable),
  .voltageReject(voltageReject), .gpPinOe(gpPinOe)
);
`default_nettype wire

// [test/testbench.sv]
// Self-checking testbench for the power rail supervisor over its register port.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; $display("ERROR %0t: got %0h expected %0h", $time, (got), (exp)); end end
module testbench;
  logic clk, rst_b, clkEn, regWr, regRd, adjRailEnable, passRailEnable, adjCurrentFoldback;
  logic passOverCurrent, adjOverCurrent, boardOverTemp, stageOverTemp, adjOverVoltage, adjPowerGood;
  logic switcherEnable, linearEnable, remoteSenseEnable, voltageReject;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, adjVoltageSet;
  logic [15:0] inputMillivolts, adjCurrentLimit, passCurrentLimit;
  logic [1:0] gpPinOut, gpPinOe, extLevel;
  wire logic [1:0] gpPinIn;
  logic [15:0] mvTab [4] = '{16'h1C20, 16'h1BE4, 16'h1C20, 16'h1C5C};
  int error_cnt = 0;
  int cmp_count = 0;

  // The pin wire follows the design while it drives, else the outside level.
  assign gpPinIn = (gpPinOe & gpPinOut) | (~gpPinOe & extLevel);

  // Design under test with a short settle count.
  power_rail_supervisor #(.START_CYCLES(4)) i_power_rail_supervisor (
    .clk(clk), .rst_b(rst_b), .clkEn(clkEn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .passOverCurrent(passOverCurrent), .adjOverCurrent(adjOverCurrent),
    .boardOverTemp(boardOverTemp), .stageOverTemp(stageOverTemp), .adjOverVoltage(adjOverVoltage),
    .adjPowerGood(adjPowerGood), .inputMillivolts(inputMillivolts), .adjRailEnable(adjRailEnable),
    .passRailEnable(passRailEnable), .adjCurrentLimit(adjCurrentLimit), .passCurrentLimit(passCurrentLimit),
    .adjVoltageSet(adjVoltageSet), .adjCurrentFoldback(adjCurrentFoldback), .switcherEnable(switcherEnable),
    .linearEnable(linearEnable), .remoteSenseEnable(remoteSenseEnable), .voltageReject(voltageReject),
    .gpPinIn(gpPinIn), .gpPinOut(gpPinOut), .gpPinOe(gpPinOe)
  );

  // Clock of 8 ns period.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Prints the verdict and stops.
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // One-cycle read strobe; data is taken in the following cycle.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 `CHK(regRdata, e)
  endtask

  // Lets a number of edges pass and settles after the last.
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    conclude();
  end

  // Main sequence.
  initial begin
    {rst_b, regWr, regRd, passOverCurrent, adjOverCurrent, boardOverTemp} = 6'h00;
    {stageOverTemp, adjOverVoltage, adjPowerGood} = 3'h0;
    clkEn = 1'b1;
    regAddr = 8'h00;
    regWdata = 32'h0;
    inputMillivolts = 16'h0000;
    extLevel = 2'h2;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    // Addresses below are the byte offsets of the register map.
    rd(8'h04, 32'h0BB8);
    rd(8'h0C, 32'h004C4B40);
    rd(8'h10, 32'h1);
    rd(8'hFC, 32'h0);
    // Rails switch on and off independently; limits clamp at three amperes.
    wr(8'h00, 32'h1);
    #1 `CHK({passRailEnable, adjRailEnable}, 2'h1)
    wr(8'h00, 32'h2);
    rd(8'h00, 32'h6);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h0BB9);
    #1 `CHK({adjCurrentLimit, passCurrentLimit}, 32'h00000BB8)
    // Over-current: foldback on one rail, trip and sticky error on the other.
    wr(8'h00, 32'h3);
    @(posedge clk) passOverCurrent <= 1'b1;
    @(posedge clk) adjOverCurrent <= 1'b1;
    wt(5);
    `CHK({passRailEnable, adjRailEnable, adjCurrentFoldback}, 3'h3)
    @(posedge clk) passOverCurrent <= 1'b0;
    @(posedge clk) adjOverCurrent <= 1'b0;
    rd(8'h1C, 32'h1);
    wr(8'h00, 32'h3);
    wt(4);
    `CHK(passRailEnable, 1'b0)
    wr(8'h1C, 32'h1);
    wr(8'h00, 32'h3);
    #1 `CHK(passRailEnable, 1'b1)
    // Voltage above the range is refused and flagged.
    wr(8'h0C, 32'h004C4B41);
    #1 `CHK(voltageReject, 1'b1)
    rd(8'h0C, 32'h004C4B40);
    wr(8'h0C, 32'h00124F80);
    #1 `CHK(adjVoltageSet, 32'h00124F80)
    // Path modes, an illegal code, and the automatic threshold with hysteresis.
    @(posedge clk) inputMillivolts <= 16'h1C84;
    wt(4);
    rd(8'h10, 32'h1);
    wr(8'h10, 32'h3);
    wr(8'h10, 32'h2);
    rd(8'h10, 32'h7);
    wr(8'h10, 32'h0);
    rd(8'h10, 32'h4);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) inputMillivolts <= mvTab[i];
      wt(4);
      `CHK(switcherEnable, (i == 0 || i == 3))
    end
    // Remote sense, then over-voltage off and automatic resume.
    wr(8'h18, 32'h1);
    rd(8'h18, 32'h3);
    @(posedge clk) adjOverVoltage <= 1'b1;
    wt(4);
    rd(8'h18, 32'h1);
    @(posedge clk) adjOverVoltage <= 1'b0;
    wt(4);
    `CHK({adjRailEnable, remoteSenseEnable}, 2'h3)
    rd(8'h1C, 32'hC);
    // Over-temperature needs an off then an on command.
    @(posedge clk) boardOverTemp <= 1'b1;
    wt(4);
    @(posedge clk) boardOverTemp <= 1'b0;
    wr(8'h00, 32'h1);
    wt(4);
    `CHK(adjRailEnable, 1'b0)
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h1);
    #1 `CHK(adjRailEnable, 1'b1)
    // Operational state codes and the linear stage under overheat.
    @(posedge clk) adjPowerGood <= 1'b1;
    wt(10);
    rd(8'h14, 32'h1);
    @(posedge clk) stageOverTemp <= 1'b1;
    wt(4);
    `CHK(linearEnable, 1'b0)
    rd(8'h14, 32'h3);
    @(posedge clk) stageOverTemp <= 1'b0;
    @(posedge clk) adjPowerGood <= 1'b0;
    wt(4);
    rd(8'h14, 32'h2);
    wr(8'h00, 32'h0);
    rd(8'h14, 32'h0);
    // Pins: output drives, floating ignores writes, input reads the wire.
    wr(8'h20, 32'h41);
    rd(8'h20, 32'h41);
    wr(8'h24, 32'h3);
    wt(4);
    `CHK({gpPinOe, gpPinOut[0]}, 3'h3)
    rd(8'h24, 32'h1);
    wr(8'h20, 32'h0);
    wr(8'h20, 32'h2);
    wt(4);
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h2);
    // Saved settings apply only after save and reboot.
    wr(8'h28, 32'h00A5C3);
    wr(8'h2C, 32'h2);
    rd(8'h30, 32'h0);
    wr(8'h2C, 32'h1);
    wr(8'h2C, 32'h2);
    rd(8'h30, 32'h00A5C3);
    conclude();
  end
endmodule
`default_nettype wire
